// ===== verilog/pecfg_pkg.sv
// Shared constants for the extended configuration access target and its bus master
package pecfg_pkg;
   localparam int CLK_PERIOD_NS = 4;
   localparam logic [3:0] CMD_CFG_RD = 4'hA;
   localparam logic [3:0] CMD_CFG_WR = 4'hB;
   localparam int RETRY_CLKS = 16;
   localparam int DEVSEL_DEADLINE_CLKS = 5;
   localparam int CNT_W = 8;
   localparam logic [5:0] CAP_FIRST_DW = 6'h10;
   localparam logic [31:0] AD_RST = 32'h0000_0000;
   localparam logic [3:0] BE_RST = 4'hF;
endpackage : pecfg_pkg

// ===== verilog/pecfg_pci_if.sv
// Shared PCI bus wires between the configuration master and the target
`timescale 1ns/1ns
interface pecfg_pci_if;
   logic mst_frame_n;
   logic mst_frame_oe;
   logic mst_idsel;
   logic [31:0] mst_ad_out;
   logic mst_ad_oe;
   logic [3:0] mst_cbe_n;
   logic mst_cbe_oe;
   logic mst_irdy_n;
   logic mst_irdy_oe;
   logic [31:0] tgt_ad_out;
   logic tgt_ad_oe;
   logic tgt_devsel_n;
   logic tgt_devsel_oe;
   logic tgt_trdy_n;
   logic tgt_trdy_oe;
   logic tgt_stop_n;
   logic tgt_stop_oe;
   logic frame_n;
   logic idsel;
   logic [31:0] ad;
   logic [3:0] cbe_n;
   logic irdy_n;
   logic devsel_n;
   logic trdy_n;
   logic stop_n;

   // Released control lines read high as if pulled up
   assign frame_n = mst_frame_oe ? mst_frame_n : 1'b1;
   assign idsel = mst_idsel;
   assign ad = mst_ad_oe ? mst_ad_out : (tgt_ad_oe ? tgt_ad_out : pecfg_pkg::AD_RST);
   assign cbe_n = mst_cbe_oe ? mst_cbe_n : pecfg_pkg::BE_RST;
   assign irdy_n = mst_irdy_oe ? mst_irdy_n : 1'b1;
   assign devsel_n = tgt_devsel_oe ? tgt_devsel_n : 1'b1;
   assign trdy_n = tgt_trdy_oe ? tgt_trdy_n : 1'b1;
   assign stop_n = tgt_stop_oe ? tgt_stop_n : 1'b1;

   modport master (
      output mst_frame_n, mst_frame_oe, mst_idsel, mst_ad_out, mst_ad_oe,
      output mst_cbe_n, mst_cbe_oe, mst_irdy_n, mst_irdy_oe,
      input frame_n, ad, irdy_n, devsel_n, trdy_n, stop_n
   );
   modport target (
      output tgt_ad_out, tgt_ad_oe, tgt_devsel_n, tgt_devsel_oe,
      output tgt_trdy_n, tgt_trdy_oe, tgt_stop_n, tgt_stop_oe,
      input frame_n, idsel, ad, cbe_n, irdy_n
   );
endinterface : pecfg_pci_if

// ===== verilog/pecfg_target.sv
// Target end: extended configuration read/write sequencing toward a back-end
`timescale 1ns/1ns
module pecfg_target #(
   parameter int RETRY_CLKS = pecfg_pkg::RETRY_CLKS,
   parameter logic [5:0] CAP_FIRST_DW = pecfg_pkg::CAP_FIRST_DW
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_clk_en,
   pecfg_pci_if.target bus,
   input wire logic i_select_speed_setting,
   input wire logic i_backend_ready_n,
   input wire logic [31:0] i_rd_data,
   output logic [31:0] o_target_addr_to_backend,
   output logic o_cap_hit,
   output logic o_transfer_strobe_n,
   output logic [31:0] o_wr_data,
   output logic [3:0] o_byte_en_n,
   output logic o_is_write,
   output logic o_retry
);
   typedef enum logic [2:0] {T_IDLE, T_DECODE, T_SELECT, T_DATA, T_RETRY, T_END, T_SKIP} pecfg_tstate_t;

   typedef struct packed {
      pecfg_tstate_t st;
      logic [31:0] addr;
      logic wr;
      logic [3:0] be_n;
      logic hit;
      logic devsel_n;
      logic devsel_oe;
      logic trdy_n;
      logic trdy_oe;
      logic stop_n;
      logic stop_oe;
      logic [31:0] ad_out;
      logic ad_oe;
      logic strobe_n;
      logic rdy_seen;
      logic [31:0] wr_data;
      logic retry;
      logic [pecfg_pkg::CNT_W-1:0] cnt;
   } pecfg_tregs_t;

   localparam pecfg_tregs_t RST_VAL = '{
      st: T_IDLE, addr: pecfg_pkg::AD_RST, wr: 1'b0, be_n: pecfg_pkg::BE_RST, hit: 1'b0,
      devsel_n: 1'b1, devsel_oe: 1'b0, trdy_n: 1'b1, trdy_oe: 1'b0, stop_n: 1'b1,
      stop_oe: 1'b0, ad_out: pecfg_pkg::AD_RST, ad_oe: 1'b0, strobe_n: 1'b1,
      rdy_seen: 1'b0, wr_data: pecfg_pkg::AD_RST, retry: 1'b0, cnt: '0
   };
   localparam logic [pecfg_pkg::CNT_W-1:0] RETRY_AT = pecfg_pkg::CNT_W'(RETRY_CLKS - 2);

   pecfg_tregs_t r;
   pecfg_tregs_t r_nxt;
   logic cfg_cmd;
   logic addr_match;

   assign cfg_cmd = (bus.cbe_n == pecfg_pkg::CMD_CFG_RD) || (bus.cbe_n == pecfg_pkg::CMD_CFG_WR);
   // Dword-aligned type-0 access into the extended capability area
   assign addr_match = (r.addr[1:0] == 2'b00) && (r.addr[7:2] >= CAP_FIRST_DW);

   always_comb
   begin
      r_nxt = r;
      case (r.st)
         T_IDLE:
         begin
            r_nxt.retry = 1'b0;
            // Only an idsel-qualified configuration cycle is ours
            if (!bus.frame_n && bus.idsel && cfg_cmd)
            begin
               r_nxt.addr = bus.ad;
               r_nxt.wr = (bus.cbe_n == pecfg_pkg::CMD_CFG_WR);
               r_nxt.cnt = pecfg_pkg::CNT_W'(1);
               r_nxt.st = T_DECODE;
            end
            else if (!bus.frame_n)
            begin
               r_nxt.st = T_SKIP;
            end
         end
         T_DECODE:
         begin
            r_nxt.be_n = bus.cbe_n;
            r_nxt.cnt = r.cnt + 1'b1;
            if (addr_match)
            begin
               r_nxt.hit = 1'b1;
               r_nxt.trdy_n = 1'b1;
               r_nxt.trdy_oe = 1'b1;
               r_nxt.stop_n = 1'b1;
               r_nxt.stop_oe = 1'b1;
               if (i_select_speed_setting)
               begin
                  r_nxt.st = T_SELECT;
               end
               else
               begin
                  r_nxt.devsel_n = 1'b0;
                  r_nxt.devsel_oe = 1'b1;
                  r_nxt.st = T_DATA;
               end
            end
            else
            begin
               r_nxt.st = T_SKIP;
            end
         end
         T_SELECT:
         begin
            r_nxt.cnt = r.cnt + 1'b1;
            r_nxt.devsel_n = 1'b0;
            r_nxt.devsel_oe = 1'b1;
            r_nxt.rdy_seen = !i_backend_ready_n;
            if (!r.wr && !i_backend_ready_n)
            begin
               r_nxt.strobe_n = 1'b0;
            end
            r_nxt.st = T_DATA;
         end
         T_DATA:
         begin
            r_nxt.cnt = r.cnt + 1'b1;
            r_nxt.rdy_seen = !i_backend_ready_n;
            if (!r.trdy_n && !bus.irdy_n)
            begin
               // Data phase done: drive deasserted levels for one cycle
               r_nxt.devsel_n = 1'b1;
               r_nxt.trdy_n = 1'b1;
               r_nxt.ad_oe = 1'b0;
               if (r.wr)
               begin
                  r_nxt.wr_data = bus.ad;
                  r_nxt.strobe_n = 1'b0;
               end
               else
               begin
                  r_nxt.hit = 1'b0;
                  r_nxt.strobe_n = 1'b1;
               end
               r_nxt.st = T_END;
            end
            else if (r.trdy_n)
            begin
               if (!r.wr)
               begin
                  if (!i_backend_ready_n)
                  begin
                     r_nxt.strobe_n = 1'b0;
                  end
                  // Ready seen on two consecutive edges means the read word is valid now
                  if (!i_backend_ready_n && r.rdy_seen)
                  begin
                     r_nxt.trdy_n = 1'b0;
                     r_nxt.ad_out = i_rd_data;
                     r_nxt.ad_oe = 1'b1;
                  end
               end
               else if (!i_backend_ready_n)
               begin
                  r_nxt.trdy_n = 1'b0;
               end
               if (r_nxt.trdy_n && (r.cnt >= RETRY_AT))
               begin
                  r_nxt.stop_n = 1'b0;
                  r_nxt.strobe_n = 1'b1;
                  r_nxt.ad_oe = 1'b0;
                  r_nxt.retry = 1'b1;
                  r_nxt.st = T_RETRY;
               end
            end
         end
         T_RETRY:
         begin
            // Hold stop until the master drops frame on its last phase
            if (bus.frame_n && !bus.irdy_n)
            begin
               r_nxt.devsel_n = 1'b1;
               r_nxt.stop_n = 1'b1;
               r_nxt.hit = 1'b0;
               r_nxt.st = T_END;
            end
         end
         T_END:
         begin
            r_nxt.hit = 1'b0;
            r_nxt.strobe_n = 1'b1;
            r_nxt.devsel_oe = 1'b0;
            r_nxt.trdy_oe = 1'b0;
            r_nxt.stop_oe = 1'b0;
            r_nxt.ad_oe = 1'b0;
            r_nxt.rdy_seen = 1'b0;
            r_nxt.st = T_IDLE;
         end
         T_SKIP:
         begin
            // Not addressed: wait for the bus to go idle
            if (bus.frame_n && bus.irdy_n)
            begin
               r_nxt.st = T_IDLE;
            end
         end
         default:
         begin
            r_nxt = RST_VAL;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         r <= RST_VAL;
      end
      else if (i_clk_en)
      begin
         r <= r_nxt;
      end
   end

   assign bus.tgt_ad_out = r.ad_out;
   assign bus.tgt_ad_oe = r.ad_oe;
   assign bus.tgt_devsel_n = r.devsel_n;
   assign bus.tgt_devsel_oe = r.devsel_oe;
   assign bus.tgt_trdy_n = r.trdy_n;
   assign bus.tgt_trdy_oe = r.trdy_oe;
   assign bus.tgt_stop_n = r.stop_n;
   assign bus.tgt_stop_oe = r.stop_oe;
   assign o_target_addr_to_backend = r.addr;
   assign o_cap_hit = r.hit;
   assign o_transfer_strobe_n = r.strobe_n;
   assign o_wr_data = r.wr_data;
   assign o_byte_en_n = r.be_n;
   assign o_is_write = r.wr;
   assign o_retry = r.retry;
endmodule : pecfg_target

// ===== verilog/pecfg_master.sv
// Master end: issues single-dword configuration reads and writes with idsel
`timescale 1ns/1ns
module pecfg_master #(
   parameter int DEVSEL_DEADLINE_CLKS = pecfg_pkg::DEVSEL_DEADLINE_CLKS
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_clk_en,
   pecfg_pci_if.master bus,
   input wire logic i_req,
   input wire logic i_write,
   input wire logic [31:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_be_n,
   output logic o_busy,
   output logic o_done,
   output logic [31:0] o_rdata,
   output logic o_retried,
   output logic o_aborted
);
   typedef enum logic [2:0] {M_IDLE, M_ADDR, M_DATA, M_STOP, M_TURN} pecfg_mstate_t;

   typedef struct packed {
      pecfg_mstate_t st;
      logic frame_n;
      logic frame_oe;
      logic idsel;
      logic [31:0] ad_out;
      logic ad_oe;
      logic [3:0] cbe_n;
      logic cbe_oe;
      logic irdy_n;
      logic irdy_oe;
      logic wr;
      logic [31:0] wdata;
      logic [3:0] be_n;
      logic [31:0] rdata;
      logic done;
      logic retried;
      logic aborted;
      logic [pecfg_pkg::CNT_W-1:0] cnt;
   } pecfg_mregs_t;

   localparam pecfg_mregs_t RST_VAL = '{
      st: M_IDLE, frame_n: 1'b1, frame_oe: 1'b0, idsel: 1'b0, ad_out: pecfg_pkg::AD_RST,
      ad_oe: 1'b0, cbe_n: pecfg_pkg::BE_RST, cbe_oe: 1'b0, irdy_n: 1'b1, irdy_oe: 1'b0,
      wr: 1'b0, wdata: pecfg_pkg::AD_RST, be_n: pecfg_pkg::BE_RST, rdata: pecfg_pkg::AD_RST,
      done: 1'b0, retried: 1'b0, aborted: 1'b0, cnt: '0
   };
   localparam logic [pecfg_pkg::CNT_W-1:0] ABORT_AT = pecfg_pkg::CNT_W'(DEVSEL_DEADLINE_CLKS - 2);

   pecfg_mregs_t r;
   pecfg_mregs_t r_nxt;

   always_comb
   begin
      r_nxt = r;
      r_nxt.done = 1'b0;
      case (r.st)
         M_IDLE:
         begin
            if (i_req && bus.frame_n && bus.irdy_n)
            begin
               r_nxt.frame_n = 1'b0;
               r_nxt.frame_oe = 1'b1;
               r_nxt.idsel = 1'b1;
               r_nxt.ad_out = i_addr;
               r_nxt.ad_oe = 1'b1;
               r_nxt.cbe_n = i_write ? pecfg_pkg::CMD_CFG_WR : pecfg_pkg::CMD_CFG_RD;
               r_nxt.cbe_oe = 1'b1;
               r_nxt.wr = i_write;
               r_nxt.wdata = i_wdata;
               r_nxt.be_n = i_be_n;
               r_nxt.retried = 1'b0;
               r_nxt.aborted = 1'b0;
               r_nxt.cnt = '0;
               r_nxt.st = M_ADDR;
            end
         end
         M_ADDR:
         begin
            r_nxt.idsel = 1'b0;
            r_nxt.cbe_n = r.be_n;
            r_nxt.irdy_n = 1'b0;
            r_nxt.irdy_oe = 1'b1;
            r_nxt.ad_out = r.wdata;
            r_nxt.ad_oe = r.wr;
            r_nxt.st = M_DATA;
         end
         M_DATA:
         begin
            r_nxt.cnt = r.cnt + 1'b1;
            if (!bus.trdy_n && !r.irdy_n)
            begin
               if (!r.wr)
               begin
                  r_nxt.rdata = bus.ad;
               end
               r_nxt.frame_oe = 1'b0;
               r_nxt.cbe_oe = 1'b0;
               r_nxt.ad_oe = 1'b0;
               r_nxt.irdy_n = 1'b1;
               r_nxt.done = 1'b1;
               r_nxt.st = M_TURN;
            end
            else if (!bus.stop_n)
            begin
               r_nxt.frame_n = 1'b1;
               r_nxt.retried = 1'b1;
               r_nxt.st = M_STOP;
            end
            else if (bus.devsel_n && (r.cnt >= ABORT_AT))
            begin
               // Nobody claimed the cycle: master abort
               r_nxt.frame_oe = 1'b0;
               r_nxt.cbe_oe = 1'b0;
               r_nxt.ad_oe = 1'b0;
               r_nxt.irdy_n = 1'b1;
               r_nxt.aborted = 1'b1;
               r_nxt.done = 1'b1;
               r_nxt.st = M_TURN;
            end
         end
         M_STOP:
         begin
            if (bus.devsel_n)
            begin
               r_nxt.frame_oe = 1'b0;
               r_nxt.cbe_oe = 1'b0;
               r_nxt.ad_oe = 1'b0;
               r_nxt.irdy_n = 1'b1;
               r_nxt.done = 1'b1;
               r_nxt.st = M_TURN;
            end
         end
         M_TURN:
         begin
            r_nxt.irdy_oe = 1'b0;
            r_nxt.st = M_IDLE;
         end
         default:
         begin
            r_nxt = RST_VAL;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         r <= RST_VAL;
      end
      else if (i_clk_en)
      begin
         r <= r_nxt;
      end
   end

   assign bus.mst_frame_n = r.frame_n;
   assign bus.mst_frame_oe = r.frame_oe;
   assign bus.mst_idsel = r.idsel;
   assign bus.mst_ad_out = r.ad_out;
   assign bus.mst_ad_oe = r.ad_oe;
   assign bus.mst_cbe_n = r.cbe_n;
   assign bus.mst_cbe_oe = r.cbe_oe;
   assign bus.mst_irdy_n = r.irdy_n;
   assign bus.mst_irdy_oe = r.irdy_oe;
   assign o_busy = (r.st != M_IDLE);
   assign o_done = r.done;
   assign o_rdata = r.rdata;
   assign o_retried = r.retried;
   assign o_aborted = r.aborted;
endmodule : pecfg_master

// ===== dv/pecfg_chk.sv
// Wire-level checks between the configuration master and the target
`timescale 1ns/1ns
module pecfg_chk (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic frame_n,
   input wire logic idsel,
   input wire logic irdy_n,
   input wire logic devsel_n,
   input wire logic trdy_n,
   input wire logic stop_n,
   input wire logic tgt_ad_oe,
   input wire logic tgt_devsel_oe,
   input wire logic tgt_trdy_oe,
   input wire logic i_select_speed_setting,
   input wire logic i_backend_ready_n,
   input wire logic o_cap_hit,
   input wire logic o_transfer_strobe_n
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);

   AST_HIT_CAUSE: assert property ($rose(o_cap_hit) |-> $past(idsel, 2) && !$past(frame_n, 2))
      else $error("hit without a selected address phase");
   AST_SLOW_DEVSEL: assert property ($rose(o_cap_hit) && i_select_speed_setting |-> devsel_n ##1 !devsel_n)
      else $error("slow select not one clock after hit");
   AST_FAST_DEVSEL: assert property ($rose(o_cap_hit) && !i_select_speed_setting |-> !devsel_n)
      else $error("fast select not with hit");
   AST_TRDY_CAUSE: assert property ($fell(trdy_n) |-> !$past(i_backend_ready_n))
      else $error("target ready without back-end ready");
   AST_READ_TWO_READY: assert property ($fell(trdy_n) && tgt_ad_oe |-> !$past(i_backend_ready_n, 2))
      else $error("read data before two ready cycles");
   AST_STROBE_CAUSE: assert property ($fell(o_transfer_strobe_n) |-> !$past(i_backend_ready_n) && o_cap_hit)
      else $error("strobe without ready");
   AST_READ_END: assert property (!trdy_n && !irdy_n && tgt_ad_oe |=>
      !tgt_ad_oe && !o_cap_hit && o_transfer_strobe_n)
      else $error("read end sequence wrong");
   AST_WRITE_END: assert property (!trdy_n && !irdy_n && !tgt_ad_oe |=>
      !o_transfer_strobe_n ##1 (!o_cap_hit && o_transfer_strobe_n))
      else $error("write strobe or completion wrong");
   AST_DEASSERT: assert property (!trdy_n && !irdy_n |=> tgt_devsel_oe && tgt_trdy_oe && devsel_n && trdy_n)
      else $error("select and ready not driven high after data phase");
   AST_RELEASE: assert property (!trdy_n && !irdy_n |=> ##1 (!tgt_devsel_oe && !tgt_trdy_oe))
      else $error("select and ready not released");
   AST_HIT_HELD: assert property (o_cap_hit && !devsel_n && trdy_n && stop_n |=> o_cap_hit)
      else $error("hit dropped before completion");
   AST_MASTER_RELEASE: assert property (!trdy_n && !irdy_n |=> frame_n && irdy_n)
      else $error("master did not release frame and irdy after data phase");
endmodule : pecfg_chk

// ===== dv/test_pci_ext_config_target_access.sv
// Bench: master and target joined, back-end and expected results modelled here
`timescale 1ns/1ns
module test_pci_ext_config_target_access;
   logic i_sys_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_req = 1'b0;
   logic i_write = 1'b0;
   logic [31:0] i_addr = 32'h0;
   logic [31:0] i_wdata = 32'h0;
   logic [3:0] i_be_n = 4'hF;
   logic i_select_speed_setting = 1'b1;
   logic i_backend_ready_n = 1'b1;
   logic [31:0] i_rd_data = 32'h0;
   logic o_done, o_retried, o_aborted, o_cap_hit, o_transfer_strobe_n, o_is_write, o_retry;
   logic [31:0] o_rdata, o_target_addr_to_backend, o_wr_data, seen_addr, seen_wdata, bk_word;
   logic [3:0] o_byte_en_n, seen_be;
   logic hit_seen = 1'b0;
   logic retry_seen = 1'b0;
   int mismatches = 0;
   int compares = 0;
   int cycles = 0;
   int bk_delay = 0;
   int bk_cnt = 0;
   int tn = 0;

   pecfg_pci_if pci ();
   pecfg_master pecfg_master_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(1'b1), .bus(pci),
      .i_req(i_req), .i_write(i_write), .i_addr(i_addr), .i_wdata(i_wdata), .i_be_n(i_be_n), .o_busy(),
      .o_done(o_done), .o_rdata(o_rdata), .o_retried(o_retried), .o_aborted(o_aborted));
   pecfg_target pecfg_target_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(1'b1), .bus(pci),
      .i_select_speed_setting(i_select_speed_setting), .i_backend_ready_n(i_backend_ready_n),
      .i_rd_data(i_rd_data), .o_target_addr_to_backend(o_target_addr_to_backend), .o_cap_hit(o_cap_hit),
      .o_transfer_strobe_n(o_transfer_strobe_n), .o_wr_data(o_wr_data), .o_byte_en_n(o_byte_en_n),
      .o_is_write(o_is_write), .o_retry(o_retry));
   pecfg_chk pecfg_chk_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .frame_n(pci.frame_n), .idsel(pci.idsel),
      .irdy_n(pci.irdy_n), .devsel_n(pci.devsel_n), .trdy_n(pci.trdy_n), .stop_n(pci.stop_n),
      .tgt_ad_oe(pci.tgt_ad_oe), .tgt_devsel_oe(pci.tgt_devsel_oe), .tgt_trdy_oe(pci.tgt_trdy_oe),
      .i_select_speed_setting(i_select_speed_setting), .i_backend_ready_n(i_backend_ready_n),
      .o_cap_hit(o_cap_hit), .o_transfer_strobe_n(o_transfer_strobe_n));

   always #2 i_sys_clk = ~i_sys_clk;

   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Back-end: ready after bk_delay hit cycles; a negative delay never answers
   always @(posedge i_sys_clk)
   begin
      cycles <= cycles + 1;
      bk_cnt <= o_cap_hit ? bk_cnt + 1 : 0;
      if (o_cap_hit && !hit_seen)
         seen_addr <= o_target_addr_to_backend;
      if (o_cap_hit)
         hit_seen <= 1'b1;
      // Retry flag clears on the first idle cycle, so latch it here
      if (o_retry)
         retry_seen <= 1'b1;
      i_backend_ready_n <= !(o_cap_hit && bk_delay >= 0 && bk_cnt >= bk_delay);
      // Noise until ready so a word taken too early cannot match
      i_rd_data <= !i_backend_ready_n ? bk_word : $urandom;
      if (!o_transfer_strobe_n && o_is_write)
      begin
         seen_wdata <= o_wr_data;
         seen_be <= o_byte_en_n;
      end
      if (cycles == 3000)
      begin
         mismatches++;
         give_verdict();
      end
   end

   task automatic run(input logic wr, input logic slow, input logic [31:0] addr, input int dly);
      logic match;
      logic [31:0] data;
      logic [3:0] be;
      int n;
      match = addr[1:0] == 2'b00 && addr[7:2] >= pecfg_pkg::CAP_FIRST_DW;
      data = $urandom;
      be = 4'($urandom);
      repeat (2) @(posedge i_sys_clk);
      #1;
      hit_seen = 1'b0;
      retry_seen = 1'b0;
      bk_delay = dly;
      bk_word = $urandom;
      @(posedge i_sys_clk);
      i_req <= 1'b1;
      i_write <= wr;
      i_addr <= addr;
      i_wdata <= data;
      i_be_n <= be;
      i_select_speed_setting <= slow;
      @(posedge i_sys_clk);
      i_req <= 1'b0;
      n = 0;
      do
      begin
         @(posedge i_sys_clk);
         #1;
         n++;
      end
      while (o_done !== 1'b1 && n < 40);
      check("done", 32'(o_done), 32'h1);
      @(posedge i_sys_clk);
      #1;
      check("hit", 32'(hit_seen), 32'(match));
      check("aborted", 32'(o_aborted), 32'(!match));
      check("retried", 32'(o_retried), 32'(match && dly < 0));
      check("retry", 32'(retry_seen), 32'(match && dly < 0));
      if (match)
         check("addr", seen_addr, addr);
      if (match && dly >= 0 && !wr)
         check("rdata", o_rdata, bk_word);
      if (match && dly >= 0 && wr)
      begin
         check("wdata", seen_wdata, data);
         check("be", 32'(seen_be), 32'(be));
      end
      $display("test %0d done", tn);
      tn++;
   endtask : run

   initial
   begin
      int t;
      logic [31:0] a;
      void'($urandom(32'h3657));
      repeat (4) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      for (t = 0; t < 12; t++)
      begin
         a = {24'($urandom), 6'h10 + 6'($urandom % 48), 2'b00};
         run(t[0], t[1], t == 0 ? 32'h40 : a, t / 4);
      end
      run(1'b0, 1'b1, 32'h3C, 0);
      run(1'b1, 1'b0, 32'h41, 0);
      run(1'b0, 1'b1, 32'hFC, -1);
      run(1'b1, 1'b0, 32'h80, -1);
      give_verdict();
   end
endmodule : test_pci_ext_config_target_access
